/* File: rtl/pmbwt_lin11.sv */
`timescale 1ns/1ps
`default_nettype none
module pmbwt_lin11 (
  // encoded linear word
  input  wire logic [15:0]                   word,
  // value with FRAC fraction bits
  output logic signed [pmbwt_pkg::VAL_W-1:0] value,
  output logic                               exact
);
  import pmbwt_pkg::*;

  logic signed [5:0]       shift;
  logic [5:0]              neg;
  logic signed [VAL_W-1:0] man_ext;
  logic [VAL_W-1:0]        lost_mask;

  // value = mantissa * 2^exponent, both signed
  always_comb begin
    shift   = 6'(signed'(word[EXP_MSB:EXP_LSB])) + 6'(FRAC);
    neg     = 6'(-shift);
    man_ext = VAL_W'(signed'(word[MAN_MSB:0]));
    if (!shift[5]) begin
      value     = man_ext <<< shift[4:0];
      lost_mask = '0;
    end else begin
      value     = man_ext >>> neg;
      lost_mask = (VAL_W'(1) << neg) - VAL_W'(1);
    end
    // bits below 1/256 are dropped, so flag them
    exact = ((man_ext & lost_mask) == '0);
  end

endmodule : pmbwt_lin11
`default_nettype wire

/* File: rtl/pmbwt_pkg.sv */
package pmbwt_pkg;

  // ****************************************
  // command codes and field layout
  // ****************************************
  localparam logic [7:0]  CMD_UV_WARN   = 8'h58;
  localparam logic [7:0]  CMD_TON_WAIT  = 8'h60;
  localparam logic [7:0]  CMD_RAMP      = 8'h61;
  localparam int          EXP_MSB       = 15;
  localparam int          EXP_LSB       = 11;
  localparam int          MAN_MSB       = 10;
  localparam logic [15:0] READ_NONE     = 16'h0000;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [4:0]  UV_EXP_RST    = 5'h1e;
  localparam logic [4:0]  WAIT_EXP_RST  = 5'h1f;
  localparam logic [4:0]  RAMP_EXP_RST  = 5'h1e;
  localparam logic [10:0] MAN_RST       = 11'h000;

  // ****************************************
  // decoded values: fixed point, FRAC fraction bits
  // ****************************************
  localparam int                 FRAC      = 8;
  localparam int                 VAL_W     = 40;
  localparam logic signed [39:0] ZERO_VAL  = 40'sh0;
  // 2.5 V and 15.5 V in 1/256 V
  localparam logic signed [39:0] UV_MIN    = 40'sh280;
  localparam logic signed [39:0] UV_MAX    = 40'shf80;
  // 2.5 V and 15.5 V as quarter-volt words
  localparam logic [15:0]        UV_MIN_WORD = 16'hf00a;
  localparam logic [15:0]        UV_MAX_WORD = 16'hf03e;
  // 127.5 ms in 1/256 ms, 0.5 ms step is 128 lsb
  localparam logic signed [39:0] WAIT_MAX  = 40'sh7f80;
  localparam logic [39:0]        WAIT_STEP_MASK = 40'h7f;
  localparam logic signed [39:0] WAIT_ROUND = 40'sh40;
  localparam int                 WAIT_STEP_SHIFT = 7;
  localparam logic signed [39:0] WAIT_HALF_MAX = 40'shff;
  // ramp time kept in quarter milliseconds
  localparam int                 RAMP_SHIFT = 6;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ          = 250;
  localparam int QMS_US           = 250;
  localparam int MIN_INIT_US      = 100;
  localparam int QMS_CYCLES       = QMS_US * CLK_MHZ;
  localparam int MIN_INIT_CYCLES  = MIN_INIT_US * CLK_MHZ;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WAIT,
    SEQ_RAMP,
    SEQ_REG
  } pmbwt_seq_t;

endpackage : pmbwt_pkg

/* File: rtl/pmbwt_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pmbwt_top #(
  parameter int QMS_CYC      = pmbwt_pkg::QMS_CYCLES,
  parameter int MIN_INIT_CYC = pmbwt_pkg::MIN_INIT_CYCLES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // command port
  input  wire logic        cmd_wr_valid,
  input  wire logic        cmd_rd_valid,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic             rd_valid_q,
  output logic [15:0]      rd_data_q,
  // status
  input  wire logic        status_clear,
  output logic             invalid_data_q,
  output logic             input_uv_warning_flag_q,
  output logic             alert_q,
  // non-volatile restore
  input  wire logic        nvm_restore,
  input  wire logic [15:0] nvm_uv_word,
  input  wire logic [15:0] nvm_wait_word,
  input  wire logic [15:0] nvm_ramp_word,
  // sequencing
  input  wire logic        start_cond,
  input  wire logic [15:0] output_voltage_setpoint,
  input  wire logic [23:0] power_input_rail,
  output logic [15:0]      ref_dac_q,
  output logic             ramp_active_q,
  output logic             in_regulation_q
);
  import pmbwt_pkg::*;
  // ****************************************
  // decoders
  // ****************************************
  logic [15:0]             uv_q;
  logic [15:0]             wait_q;
  logic [15:0]             ramp_q;
  logic signed [VAL_W-1:0] wd_val;
  logic signed [VAL_W-1:0] uv_val;
  logic signed [VAL_W-1:0] wait_val;
  logic signed [VAL_W-1:0] ramp_val;
  logic signed [VAL_W-1:0] nu_val;
  logic signed [VAL_W-1:0] nw_val;
  logic                    wd_exact;
  pmbwt_lin11 u_dec_wr   (.word(cmd_wdata),     .value(wd_val),
                          .exact(wd_exact));
  pmbwt_lin11 u_dec_uv   (.word(uv_q),          .value(uv_val),   .exact());
  pmbwt_lin11 u_dec_wait (.word(wait_q),        .value(wait_val), .exact());
  pmbwt_lin11 u_dec_ramp (.word(ramp_q),        .value(ramp_val), .exact());
  pmbwt_lin11 u_dec_nu   (.word(nvm_uv_word),   .value(nu_val),   .exact());
  pmbwt_lin11 u_dec_nw   (.word(nvm_wait_word), .value(nw_val),   .exact());
  // ****************************************
  // write checks and restore rounding
  // ****************************************
  logic                    uv_ok;
  logic                    wait_ok;
  logic                    ramp_ok;
  logic                    wr_uv;
  logic                    wr_wait;
  logic                    wr_ramp;
  logic                    bad_wr;
  logic signed [VAL_W-1:0] half_rnd;
  logic [7:0]              half_cnt;
  logic [15:0]             uv_rst_word;
  logic [15:0]             wait_rst_word;
  always_comb begin
    uv_ok   = wd_exact && wd_val >= UV_MIN && wd_val <= UV_MAX;
    wait_ok = wd_exact && wd_val >= ZERO_VAL && wd_val <= WAIT_MAX
              && (wd_val & WAIT_STEP_MASK) == '0;
    ramp_ok = wd_exact && wd_val >= ZERO_VAL;
    wr_uv   = cmd_wr_valid && cmd_code == CMD_UV_WARN;
    wr_wait = cmd_wr_valid && cmd_code == CMD_TON_WAIT;
    wr_ramp = cmd_wr_valid && cmd_code == CMD_RAMP;
    bad_wr  = (wr_uv && !uv_ok) || (wr_wait && !wait_ok)
              || (wr_ramp && !ramp_ok);
    // nearest half millisecond, clamped into range
    half_rnd = (nw_val + WAIT_ROUND) >>> WAIT_STEP_SHIFT;
    half_cnt = (half_rnd < ZERO_VAL) ? 8'h00
             : (half_rnd > WAIT_HALF_MAX) ? 8'hff : half_rnd[7:0];
    wait_rst_word = {WAIT_EXP_RST, 3'h0, half_cnt};
    uv_rst_word = (nu_val < UV_MIN) ? UV_MIN_WORD
                : (nu_val > UV_MAX) ? UV_MAX_WORD : nvm_uv_word;
  end
  // ****************************************
  // command registers
  // ****************************************
  // this instance is one phase; a stack instantiates one per phase
  always_ff @(posedge clock) begin
    if (rst) begin
      uv_q   <= {UV_EXP_RST, MAN_RST};
      wait_q <= {WAIT_EXP_RST, MAN_RST};
      ramp_q <= {RAMP_EXP_RST, MAN_RST};
    end else if (nvm_restore) begin
      uv_q   <= uv_rst_word;
      wait_q <= wait_rst_word;
      ramp_q <= nvm_ramp_word;
    end else begin
      // word-wide data, bytes already paired by the host side
      if (wr_uv && uv_ok) begin
        uv_q <= cmd_wdata;
      end
      if (wr_wait && wait_ok) begin
        wait_q <= cmd_wdata;
      end
      if (wr_ramp && ramp_ok) begin
        ramp_q <= cmd_wdata;
      end
    end
  end
  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= READ_NONE;
    end else begin
      rd_valid_q <= cmd_rd_valid;
      if (cmd_rd_valid) begin
        case (cmd_code)
          CMD_UV_WARN:  rd_data_q <= uv_q;
          CMD_TON_WAIT: rd_data_q <= wait_q;
          CMD_RAMP:     rd_data_q <= ramp_q;
          default:      rd_data_q <= READ_NONE;
        endcase
      end
    end
  end
  // ****************************************
  // status flags
  // ****************************************
  logic uv_low;
  logic invalid_d;
  logic uvw_d;
  always_comb begin
    uv_low    = signed'({16'h0000, power_input_rail}) < uv_val;
    // a new event beats a clear in the same cycle
    invalid_d = bad_wr || (invalid_data_q && !status_clear);
    uvw_d     = uv_low || (input_uv_warning_flag_q && !status_clear);
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      invalid_data_q          <= 1'b0;
      input_uv_warning_flag_q <= 1'b0;
      alert_q                 <= 1'b0;
    end else begin
      invalid_data_q          <= invalid_d;
      input_uv_warning_flag_q <= uvw_d;
      alert_q                 <= invalid_d || uvw_d;
    end
  end
  // ****************************************
  // start-up sequencer
  // ****************************************
  pmbwt_seq_t  seq_q;
  logic [31:0] cnt_q;
  logic [32:0] acc_q;
  logic        first_q;
  logic [31:0] wait_cyc;
  logic [31:0] wait_eff;
  logic [15:0] ramp_qms;
  logic [31:0] ramp_cyc;
  logic [32:0] acc_sum;
  always_comb begin
    wait_cyc = 32'(wait_val[14:7]) * (32'(QMS_CYC) << 1);
    wait_eff = (first_q && wait_cyc < 32'(MIN_INIT_CYC))
             ? 32'(MIN_INIT_CYC) : wait_cyc;
    ramp_qms = ramp_val[VAL_W-1] ? 16'h0000
             : (ramp_val[VAL_W-2:RAMP_SHIFT+16] != '0) ? 16'hffff
             : ramp_val[RAMP_SHIFT+15:RAMP_SHIFT];
    ramp_cyc = 32'(ramp_qms) * 32'(QMS_CYC);
    acc_sum  = acc_q + 33'(output_voltage_setpoint);
  end
  // slope = setpoint / ramp cycles, so time is setpoint-independent;
  // at most one lsb per cycle, so steep slopes saturate; a zero ramp time jumps straight to setpoint
  always_ff @(posedge clock) begin
    if (rst) begin
      seq_q           <= SEQ_IDLE;
      cnt_q           <= 32'h0;
      acc_q           <= 33'h0;
      first_q         <= 1'b1;
      ref_dac_q       <= 16'h0000;
      ramp_active_q   <= 1'b0;
      in_regulation_q <= 1'b0;
    end else if (!start_cond) begin
      seq_q           <= SEQ_IDLE;
      ref_dac_q       <= 16'h0000;
      ramp_active_q   <= 1'b0;
      in_regulation_q <= 1'b0;
    end else begin
      case (seq_q)
        SEQ_IDLE: begin
          seq_q <= SEQ_WAIT;
          cnt_q <= 32'h0;
        end
        SEQ_WAIT: begin
          if (cnt_q >= wait_eff) begin
            seq_q         <= SEQ_RAMP;
            acc_q         <= 33'h0;
            first_q       <= 1'b0;
            ramp_active_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        SEQ_RAMP: begin
          if (ramp_cyc == 32'h0 || ref_dac_q >= output_voltage_setpoint) begin
            ref_dac_q       <= output_voltage_setpoint;
            seq_q           <= SEQ_REG;
            ramp_active_q   <= 1'b0;
            in_regulation_q <= 1'b1;
          end else if (acc_sum >= 33'(ramp_cyc)) begin
            acc_q     <= acc_sum - 33'(ramp_cyc);
            ref_dac_q <= ref_dac_q + 16'h0001;
          end else begin
            acc_q <= acc_sum;
          end
        end
        SEQ_REG: begin
          ref_dac_q <= output_voltage_setpoint;
        end
        default: begin
          seq_q <= SEQ_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_uv_reject_keep: assert property (@(posedge clock) disable iff (rst)
    wr_uv && !uv_ok && !nvm_restore |=> uv_q == $past(uv_q))
    else $error("rejected threshold write changed register");
  a_uv_bad_alert: assert property (@(posedge clock) disable iff (rst)
    wr_uv && !uv_ok |=> invalid_data_q && alert_q)
    else $error("bad threshold write not flagged");
  a_wait_reject_flag: assert property (@(posedge clock) disable iff (rst)
    wr_wait && !wait_ok && !nvm_restore
    |=> invalid_data_q && wait_q == $past(wait_q))
    else $error("bad turn-on wait write not rejected");
  a_wait_in_range: assert property (@(posedge clock) disable iff (rst)
    wait_val >= ZERO_VAL && wait_val <= WAIT_MAX
    && (wait_val & WAIT_STEP_MASK) == '0)
    else $error("turn-on wait outside supported set");
  a_restore_form: assert property (@(posedge clock) disable iff (rst)
    nvm_restore |=> wait_q[15:11] == 5'h1f && wait_q[10:8] == 3'h0)
    else $error("restored turn-on wait not in supported form");
  a_min_init_wait: assert property (@(posedge clock) disable iff (rst)
    seq_q == SEQ_WAIT && first_q && start_cond
    && cnt_q < 32'(MIN_INIT_CYC) |=> seq_q == SEQ_WAIT)
    else $error("power-on wait shorter than minimum");
  a_wait_to_ramp: assert property (@(posedge clock) disable iff (rst)
    $rose(ramp_active_q) |-> $past(seq_q) == SEQ_WAIT
    && $past(cnt_q) >= $past(wait_eff))
    else $error("ramp began before turn-on wait ended");
  a_ramp_step: assert property (@(posedge clock) disable iff (rst)
    seq_q == SEQ_RAMP && start_cond && $past(seq_q) == SEQ_RAMP
    |-> ref_dac_q - $past(ref_dac_q) <= 16'h0001)
    else $error("reference stepped more than one lsb");
  a_reg_target: assert property (@(posedge clock) disable iff (rst)
    $rose(in_regulation_q) |-> ref_dac_q == $past(output_voltage_setpoint))
    else $error("regulation entered off target");
  a_uv_warn_set: assert property (@(posedge clock) disable iff (rst)
    uv_low |=> input_uv_warning_flag_q && alert_q)
    else $error("input undervoltage warning missed");

endmodule : pmbwt_top
`default_nettype wire

/* File: tb/pmbwt_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pmbwt_host_model (
  // clock
  input  wire logic        clock,
  // command port
  output logic             cmd_wr_valid,
  output logic             cmd_rd_valid,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata,
  // answer
  input  wire logic        rd_valid_q,
  input  wire logic [15:0] rd_data_q
);
  // ****
  // word transfers
  // ****
  initial begin
    cmd_wr_valid = 1'b0;
    cmd_rd_valid = 1'b0;
    cmd_code     = 8'h00;
    cmd_wdata    = 16'h0000;
  end

  task automatic write_word(input logic [7:0] code, input logic [15:0] w);
    logic [15:0] pair;
    pair[7:0]  = w[7:0];
    pair[15:8] = w[15:8];
    @(posedge clock) #1;
    cmd_wr_valid = 1'b1;
    cmd_code     = code;
    cmd_wdata    = pair;
    @(posedge clock) #1;
    cmd_wr_valid = 1'b0;
    // released bus shows no stale word
    cmd_code     = ~code;
    cmd_wdata    = ~pair;
  endtask : write_word

  task automatic read_word(input logic [7:0] code, output logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock) #1;
    cmd_rd_valid = 1'b1;
    cmd_code     = code;
    @(posedge clock) #1;
    cmd_rd_valid = 1'b0;
    cmd_code     = ~code;
    while (rd_valid_q !== 1'b1 && n < 4) begin
      @(posedge clock) #1;
      n++;
    end
    d = (rd_valid_q === 1'b1) ? rd_data_q : 16'hxxxx;
  endtask : read_word
endmodule : pmbwt_host_model
`default_nettype wire

/* File: tb/pmbwt_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pmbwt_top_tb;
  import pmbwt_pkg::*;
  localparam int QMS  = 4;
  localparam int MINI = 10;
  logic        clock, rst, cmd_wr_valid, cmd_rd_valid, rd_valid_q;
  logic        status_clear, invalid_data_q, input_uv_warning_flag_q;
  logic        alert_q, nvm_restore, start_cond, ramp_active_q;
  logic        in_regulation_q;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, rd_data_q, nvm_uv_word, nvm_wait_word, r;
  logic [15:0] nvm_ramp_word, output_voltage_setpoint, ref_dac_q;
  logic [23:0] power_input_rail;
  logic [15:0] shadow [3];
  logic [7:0]  codes [3];
  logic [17:0] tbl [19];
  int          err_total = 0;
  int          n_compared = 0;
  int          seed, k;

  pmbwt_top #(.QMS_CYC(QMS), .MIN_INIT_CYC(MINI)) u_pmbwt_top (
    .clock, .rst, .cmd_wr_valid, .cmd_rd_valid, .cmd_code, .cmd_wdata,
    .rd_valid_q, .rd_data_q, .status_clear, .invalid_data_q,
    .input_uv_warning_flag_q, .alert_q, .nvm_restore, .nvm_uv_word,
    .nvm_wait_word, .nvm_ramp_word, .start_cond, .output_voltage_setpoint,
    .power_input_rail, .ref_dac_q, .ramp_active_q, .in_regulation_q);
  pmbwt_host_model u_host (.clock, .cmd_wr_valid, .cmd_rd_valid,
    .cmd_code, .cmd_wdata, .rd_valid_q, .rd_data_q);

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ****
  // expectation helpers
  // ****
  function automatic longint lin(logic [15:0] w, output bit ex);
    longint m;
    int     e;
    m  = longint'($signed(w[10:0]));
    e  = int'($signed(w[15:11])) + 8;
    ex = 1'b1;
    if (e >= 0) return m <<< e;
    ex = (m & ((64'sd1 <<< -e) - 1)) == 0;
    return m >>> -e;
  endfunction : lin

  function automatic bit ok(int k, logic [15:0] w);
    bit     ex;
    longint v;
    v = lin(w, ex);
    if (k == 0) return ex && v >= 640 && v <= 3968;
    if (k == 1) return ex && v >= 0 && v <= 32640 && v % 128 == 0;
    return ex && v >= 0;
  endfunction : ok

  task automatic step();
    @(posedge clock) #1;
  endtask : step

  task automatic check(string s, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic chk_rd(logic [7:0] c, logic [15:0] e);
    u_host.read_word(c, r);
    check("readback", r, e);
  endtask : chk_rd

  task automatic put(int k, logic [15:0] w);
    logic g;
    g = ok(k, w);
    status_clear = 1'b1;
    step();
    status_clear = 1'b0;
    u_host.write_word(codes[k], w);
    check("invalid", 16'(invalid_data_q), 16'(!g));
    check("alert", 16'(alert_q), 16'(!g));
    if (g) shadow[k] = w;
    chk_rd(codes[k], shadow[k]);
  endtask : put

  task automatic run(int rise, int len, logic [15:0] sp);
    int n;
    int m;
    n = 0;
    m = 0;
    output_voltage_setpoint = sp;
    start_cond = 1'b1;
    while (ramp_active_q !== 1'b1 && n < 300) begin
      step();
      n++;
    end
    check("rise", 16'(n), 16'(rise));
    while (ramp_active_q === 1'b1 && m < 1000) begin
      step();
      m++;
    end
    if (len > 0) begin
      check("ramp", 16'(m >= len - 2 && m <= len + 2), 16'h1);
    end
    check("regulated", 16'(in_regulation_q), 16'h1);
    check("ref", ref_dac_q, sp);
    start_cond = 1'b0;
    step();
    step();
    check("idle", 16'({ramp_active_q, in_regulation_q}), 16'h0);
  endtask : run

  // ****
  // main sequence
  // ****
  initial begin
    seed = 96547;
    rst = 1'b1;
    status_clear = 1'b0;
    nvm_restore = 1'b0;
    start_cond = 1'b0;
    nvm_uv_word = 16'h0000;
    nvm_wait_word = 16'h0000;
    nvm_ramp_word = 16'h0000;
    power_input_rail = 24'hffffff;
    output_voltage_setpoint = 16'h0001;
    codes = '{CMD_UV_WARN, CMD_TON_WAIT, CMD_RAMP};
    shadow = '{16'hf000, 16'hf800, 16'hf000};
    tbl = '{{2'd0, 16'hf00a}, {2'd0, 16'hf03e}, {2'd0, 16'hf009},
      {2'd0, 16'hf03f}, {2'd0, 16'he814}, {2'd0, 16'h0003},
      {2'd0, 16'hfff0}, {2'd1, 16'hf8ff}, {2'd1, 16'hf900},
      {2'd1, 16'hf801}, {2'd1, 16'hfc00}, {2'd1, 16'he801},
      {2'd1, 16'h0081}, {2'd1, 16'hf000}, {2'd2, 16'h0008},
      {2'd2, 16'hffff}, {2'd2, 16'he001}, {2'd2, 16'hc001},
      {2'd2, 16'hb801}};
    repeat (5) @(posedge clock);
    #1 rst = 1'b0;
    for (k = 0; k < 3; k++) chk_rd(codes[k], shadow[k]);
    chk_rd(8'h5a, READ_NONE);
    foreach (tbl[i]) put(int'(tbl[i][17:16]), tbl[i][15:0]);
    repeat (300) begin
      k = {$random(seed)} % 3;
      r = 16'($random(seed));
      // bias towards small exponents so some writes land
      if (r[1]) r[15:13] = 3'b111;
      put(k, r);
    end
    nvm_uv_word = 16'hf001;
    nvm_wait_word = 16'he807;
    nvm_ramp_word = 16'h0005;
    nvm_restore = 1'b1;
    step();
    nvm_restore = 1'b0;
    shadow = '{16'hf00a, 16'hf802, 16'h0005};
    for (k = 0; k < 3; k++) chk_rd(codes[k], shadow[k]);
    put(2, 16'hf001);
    put(1, 16'hf800);
    run(MINI + 2, 0, 16'h0001);
    run(2, 0, 16'h0001);
    put(1, 16'hf802);
    run(4 * QMS + 2, 0, 16'h0001);
    put(2, 16'h0008);
    run(4 * QMS + 2, 32 * QMS, 16'h0008);
    run(4 * QMS + 2, 32 * QMS, 16'h0010);
    put(0, 16'h0008);
    power_input_rail = 24'd2048;
    step();
    step();
    check("uv", 16'(input_uv_warning_flag_q), 16'h0);
    power_input_rail = 24'd2047;
    step();
    status_clear = 1'b1;
    step();
    status_clear = 1'b0;
    check("uv", 16'({input_uv_warning_flag_q, alert_q}), 16'h3);
    power_input_rail = 24'hffffff;
    step();
    status_clear = 1'b1;
    step();
    status_clear = 1'b0;
    check("uv", 16'({input_uv_warning_flag_q, alert_q}), 16'h0);
    wrap_up();
  end

  initial begin
    #(4 * 20000);
    err_total++;
    wrap_up();
  end
endmodule : pmbwt_top_tb
`default_nettype wire
